// ==== verilog/sap_pkg.sv ====
/*
 Package for the two-wire target address and phase select block:
 strap and pin carriers, strap level codes, address and phase constants.
 Assumes an analog front end that digitises each strap into a mode bit,
 a three-level code and a resistor index.
*/
package sap_pkg;
   // ---------------------------------------------------------------
   // Strap and pin carriers
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SAP_LVL_LOW = 2'h0,
      SAP_LVL_OPEN = 2'h1,
      SAP_LVL_HIGH = 2'h2
   } sap_level_t;

   // One strap: resistor mode flag, three-level code, resistor index
   typedef struct packed {
      logic res_mode;
      sap_level_t level;
      logic [4:0] index;
   } sap_strap_t;

   // Open-drain pin driver: level driven and enable
   typedef struct packed {
      logic o;
      logic oe;
   } sap_od_t;

   // ---------------------------------------------------------------
   // Address and phase constants
   // ---------------------------------------------------------------
   localparam logic [6:0] TRI_BASE = 7'h20;
   localparam logic [6:0] TRI_ROW = 7'h03;
   localparam logic [9:0] RES_RADIX = 10'h019;
   localparam logic [4:0] IDX_MAX = 5'h18;
   localparam logic [6:0] TEST_ADDR = 7'h4b;
   localparam logic [4:0] PHASE_STEP_MAX = 5'h10;
   localparam int ADDR_BITS = 7;

   // Sync pin role codes from the configuration input
   localparam logic [1:0] SYNC_IN = 2'h0;
   localparam logic [1:0] SYNC_AUTO = 2'h1;
   localparam logic [1:0] SYNC_OUT = 2'h2;

   // ---------------------------------------------------------------
   // Timing and layout
   // ---------------------------------------------------------------
   localparam logic [2:0] SETTLE_CYC = 3'h4;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Idle levels: bus and event lines high under pull-ups, sync low,
   // so no false event is seen while the filter fills after reset
   localparam logic [3:0] PIN_RST = 4'h7;
   localparam int PIN_SCL = 0;
   localparam int PIN_SDA = 1;
   localparam int PIN_EVT = 2;
   localparam int PIN_SYNC = 3;
endpackage

// ==== verilog/sap_sync.sv ====
/*
 Three-stage input synchroniser with agreement filter.
 Assumes inputs are asynchronous to clk; output moves only when stages
 two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module sap_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sap_sync_st_t;

   sap_sync_st_t s_r;
   sap_sync_st_t s_nxt;

   // ---------------------------------------------------------------
   // Next state: first stage feeds only the second
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.s1 = d;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      for (int i = 0; i < W; i++) begin
         if (s_r.s2[i] == s_r.s3[i]) begin
            s_nxt.q[i] = s_r.s3[i];
         end
      end
   end

   // Register stage, frozen while ce is low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.q;
endmodule
`default_nettype wire

// ==== verilog/sap_addr_decode.sv ====
/*
 Strap decoder: turns two digitised straps into a 7-bit bus address
 and a valid flag. Purely combinational; the caller latches the result.
*/
`timescale 1ns/1ps
`default_nettype none
module sap_addr_decode (
   input wire sap_pkg::sap_strap_t upper,
   input wire sap_pkg::sap_strap_t lower,
   output logic [6:0] addr,
   output logic ok
);
   // ---------------------------------------------------------------
   // Address selection by strap mode
   // ---------------------------------------------------------------
   always_comb begin
      logic [9:0] sum;
      sum = 10'(sap_pkg::RES_RADIX * upper.index) + 10'(lower.index);
      addr = 7'h00;
      ok = 1'b0;
      if (!upper.res_mode && !lower.res_mode) begin
         // Row-major table, both-high left unassigned
         addr = sap_pkg::TRI_BASE + 7'(sap_pkg::TRI_ROW * upper.level) + 7'(lower.level);
         ok = (upper.level != sap_pkg::SAP_LVL_HIGH || lower.level != sap_pkg::SAP_LVL_HIGH) &&
              (upper.level <= sap_pkg::SAP_LVL_HIGH) && (lower.level <= sap_pkg::SAP_LVL_HIGH);
      end else if (!upper.res_mode && upper.level == sap_pkg::SAP_LVL_LOW) begin
         addr = {2'h0, lower.index};
         ok = lower.index <= sap_pkg::IDX_MAX;
      end else if (upper.res_mode && lower.res_mode) begin
         addr = sum[6:0];
         ok = (upper.index <= sap_pkg::IDX_MAX) && (lower.index <= sap_pkg::IDX_MAX);
      end
      // Test address never becomes a live address
      if (addr == sap_pkg::TEST_ADDR) begin
         ok = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/sap_top.sv ====
/*
 Two-wire target address and phase select block: strap latch, address
 match with acknowledge, phase step register, fault alert and event line.
 Assumes SCL/SDA and other pins are asynchronous and sampled by clk;
 fault_event and event_drive come from logic on clk.
*/
// Function
// - Three-level straps map to 0x20..0x27, both-high reserved
// - Upper low, lower resistor: address is index
// - Resistor strap resolves index 0 to 24
// - Both resistors: address is 25*upper plus lower
// - Computed address wraps modulo 128
// - Address in high seven bits, above R/W
// - Address 0x4B reserved for test, never acknowledged
// - Default phase is 45 degrees times addr[2:0]
// - Phase programmable 0-360 in 22.5 degree steps
// - SMBus-style target with separate fault alert output
// - Common switching clock; strap sets sync pin role
`timescale 1ns/1ps
`default_nettype none
module sap_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire sap_pkg::sap_strap_t address_strap_upper,
   input wire sap_pkg::sap_strap_t address_strap_lower,
   input wire logic [1:0] sync_sel,
   input wire logic scl_i,
   input wire logic sda_i,
   output sap_pkg::sap_od_t sda_od,
   input wire logic fault_event,
   output sap_pkg::sap_od_t fault_alert_output,
   input wire logic event_drive,
   input wire logic interdevice_event_line_i,
   output sap_pkg::sap_od_t interdevice_event_line,
   output logic event_seen,
   input wire logic sync_i,
   output logic sync_as_output,
   output logic [6:0] bus_addr,
   output logic addr_ok,
   output logic [4:0] phase_step,
   output logic phase_override
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_AACK = 3'h3,
      ST_WDAT = 3'h2,
      ST_DACK = 3'h6,
      ST_RDAT = 3'h7,
      ST_RACK = 3'h5
   } sap_fsm_t;

   typedef struct packed {
      sap_fsm_t fsm;
      logic [3:0] cnt;
      logic [7:0] shf;
      logic rw;
      logic host_ack;
      logic sda_oe;
      logic [2:0] init_cnt;
      logic ready;
      sap_pkg::sap_strap_t up;
      sap_pkg::sap_strap_t lo;
      logic [6:0] addr;
      logic addr_ok;
      logic ovr;
      logic [4:0] phase;
      logic alert;
      logic ev_oe;
      logic [1:0] sync_sel;
      logic sync_seen;
      logic scl_d;
      logic sda_d;
      logic sync_d;
   } sap_core_t;

   sap_core_t s_r;
   sap_core_t s_nxt;
   logic [3:0] pins;
   logic [15:0] strap_q;
   sap_pkg::sap_strap_t up_q;
   sap_pkg::sap_strap_t lo_q;
   logic [6:0] dec_addr;
   logic dec_ok;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic [7:0] rbyte;

   // ---------------------------------------------------------------
   // Pin and strap synchronisers, address decoder
   // ---------------------------------------------------------------
   sap_sync #(.W(4), .INIT(sap_pkg::PIN_RST)) u_pin_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .d({sync_i, interdevice_event_line_i, sda_i, scl_i}),
      .q(pins)
   );

   sap_sync #(.W(16)) u_strap_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .d({address_strap_upper, address_strap_lower}),
      .q(strap_q)
   );

   assign up_q = sap_pkg::sap_strap_t'(strap_q[15:8]);
   assign lo_q = sap_pkg::sap_strap_t'(strap_q[7:0]);

   sap_addr_decode u_dec (
      .upper(up_q),
      .lower(lo_q),
      .addr(dec_addr),
      .ok(dec_ok)
   );

   // Bus conditions seen on the filtered pins
   assign scl = pins[sap_pkg::PIN_SCL];
   assign sda = pins[sap_pkg::PIN_SDA];
   assign scl_rise = scl && !s_r.scl_d;
   assign scl_fall = !scl && s_r.scl_d;
   assign start_c = scl && s_r.scl_d && !sda && s_r.sda_d;
   assign stop_c = scl && s_r.scl_d && sda && !s_r.sda_d;
   // Read byte: alert flag, override flag, phase step
   assign rbyte = {s_r.alert, s_r.ovr, 1'b0, s_r.phase};

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.scl_d = scl;
      s_nxt.sda_d = sda;
      s_nxt.sync_d = pins[sap_pkg::PIN_SYNC];
      s_nxt.ev_oe = event_drive;
      // Settle the strap synchroniser, then capture once
      if (!s_r.ready) begin
         if (s_r.init_cnt == sap_pkg::SETTLE_CYC) begin
            s_nxt.ready = 1'b1;
            s_nxt.up = up_q;
            s_nxt.lo = lo_q;
            s_nxt.addr = dec_addr;
            s_nxt.addr_ok = dec_ok;
            s_nxt.phase = {1'b0, dec_addr[2:0], 1'b0};
            s_nxt.sync_sel = sync_sel;
         end else begin
            s_nxt.init_cnt = s_r.init_cnt + 3'h1;
         end
      end
      // Auto role: an outside clock edge makes this end a follower
      if (s_r.ready && pins[sap_pkg::PIN_SYNC] && !s_r.sync_d) begin
         s_nxt.sync_seen = 1'b1;
      end
      if (!s_r.ready) begin
         s_nxt.fsm = ST_IDLE;
      end else if (start_c) begin
         s_nxt.fsm = ST_ADDR;
         s_nxt.cnt = 4'h0;
         s_nxt.sda_oe = 1'b0;
      end else if (stop_c) begin
         s_nxt.fsm = ST_IDLE;
         s_nxt.sda_oe = 1'b0;
      end else begin
         case (s_r.fsm)
            ST_ADDR, ST_WDAT: begin
               if (scl_rise) begin
                  s_nxt.shf = {s_r.shf[6:0], sda};
                  s_nxt.cnt = s_r.cnt + 4'h1;
               end else if (scl_fall && s_r.cnt == sap_pkg::BYTE_BITS) begin
                  if (s_r.fsm == ST_WDAT) begin
                     s_nxt.fsm = ST_DACK;
                     s_nxt.sda_oe = 1'b1;
                     if (s_r.shf[7]) begin
                        s_nxt.ovr = 1'b0;
                        s_nxt.phase = {1'b0, s_r.addr[2:0], 1'b0};
                     end else if (s_r.shf[4:0] <= sap_pkg::PHASE_STEP_MAX) begin
                        s_nxt.ovr = 1'b1;
                        s_nxt.phase = s_r.shf[4:0];
                     end
                  end else if (s_r.shf[7:1] == s_r.addr && s_r.addr_ok) begin
                     s_nxt.fsm = ST_AACK;
                     s_nxt.sda_oe = 1'b1;
                     s_nxt.rw = s_r.shf[0];
                  end else begin
                     s_nxt.fsm = ST_IDLE;
                  end
               end
            end
            ST_AACK, ST_DACK: begin
               if (scl_fall) begin
                  if (s_r.fsm == ST_AACK && s_r.rw) begin
                     s_nxt.fsm = ST_RDAT;
                     s_nxt.shf = rbyte;
                     s_nxt.sda_oe = !rbyte[7];
                     s_nxt.cnt = 4'h1;
                     s_nxt.alert = 1'b0;
                  end else begin
                     s_nxt.fsm = ST_WDAT;
                     s_nxt.cnt = 4'h0;
                     s_nxt.sda_oe = 1'b0;
                  end
               end
            end
            ST_RDAT: begin
               if (scl_fall) begin
                  if (s_r.cnt == sap_pkg::BYTE_BITS) begin
                     s_nxt.fsm = ST_RACK;
                     s_nxt.sda_oe = 1'b0;
                  end else begin
                     s_nxt.shf = {s_r.shf[6:0], 1'b0};
                     s_nxt.sda_oe = !s_r.shf[6];
                     s_nxt.cnt = s_r.cnt + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  s_nxt.host_ack = !sda;
               end else if (scl_fall) begin
                  if (s_r.host_ack) begin
                     s_nxt.fsm = ST_RDAT;
                     s_nxt.shf = rbyte;
                     s_nxt.sda_oe = !rbyte[7];
                     s_nxt.cnt = 4'h1;
                  end else begin
                     s_nxt.fsm = ST_IDLE;
                  end
               end
            end
            default: begin
               s_nxt.fsm = ST_IDLE;
               s_nxt.sda_oe = 1'b0;
            end
         endcase
      end
      // New fault beats a clear by read in the same cycle
      if (fault_event) begin
         s_nxt.alert = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // State register, frozen while ce is low
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // Outputs; open-drain pins only ever pull low
   assign sda_od = '{o: 1'b0, oe: s_r.sda_oe};
   assign fault_alert_output = '{o: 1'b0, oe: s_r.alert};
   assign interdevice_event_line = '{o: 1'b0, oe: s_r.ev_oe};
   assign event_seen = !pins[sap_pkg::PIN_EVT];
   assign sync_as_output = s_r.ready && (s_r.sync_sel == sap_pkg::SYNC_OUT ||
                           (s_r.sync_sel == sap_pkg::SYNC_AUTO && !s_r.sync_seen));
   assign bus_addr = s_r.addr;
   assign addr_ok = s_r.addr_ok;
   assign phase_step = s_r.phase;
   assign phase_override = s_r.ovr;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !ce);

   AST_TRI_ADDR: assert property (s_r.ready && !s_r.up.res_mode && !s_r.lo.res_mode && s_r.addr_ok |->
      s_r.addr == 7'(7'h20 + 7'h03 * s_r.up.level + s_r.lo.level)) else $error("three-level address wrong");
   AST_TRI_RSVD: assert property (s_r.ready && !s_r.up.res_mode && !s_r.lo.res_mode &&
      s_r.up.level == sap_pkg::SAP_LVL_HIGH && s_r.lo.level == sap_pkg::SAP_LVL_HIGH |-> !s_r.addr_ok)
      else $error("both-high straps accepted");
   AST_RES_LOWER: assert property (s_r.ready && !s_r.up.res_mode && s_r.up.level == sap_pkg::SAP_LVL_LOW &&
      s_r.lo.res_mode |-> s_r.addr == {2'h0, s_r.lo.index}) else $error("lower index address wrong");
   AST_RES_SUM: assert property (s_r.ready && s_r.up.res_mode && s_r.lo.res_mode |->
      s_r.addr == 7'((10'h019 * s_r.up.index + s_r.lo.index) % 10'h080)) else $error("resistor sum address wrong");
   AST_TEST_RSVD: assert property (s_r.addr == 7'h4b |-> !s_r.addr_ok) else $error("test address live");
   AST_HOLD: assert property ($past(s_r.ready) |-> $stable(s_r.addr) && $stable(s_r.addr_ok))
      else $error("latched address changed");
   AST_PHASE_DEF: assert property (s_r.ready && !s_r.ovr |-> s_r.phase == {1'b0, s_r.addr[2:0], 1'b0})
      else $error("default phase wrong");
   AST_PHASE_MAX: assert property (s_r.phase <= 5'h10) else $error("phase step beyond full turn");
   AST_ACK_MATCH: assert property ($rose(s_r.fsm == ST_AACK) |-> $past(s_r.shf[7:1]) == s_r.addr &&
      s_r.addr_ok && s_r.sda_oe) else $error("acknowledge without match");
   AST_ALERT: assert property (fault_event |=> fault_alert_output.oe [*2] or ##1 !ce)
      else $error("fault did not raise alert");
   AST_EVT_OD: assert property (event_drive |=> interdevice_event_line.oe && !interdevice_event_line.o)
      else $error("event line not pulled low");

   COV_ACK: cover property (s_r.fsm == ST_ADDR ##[1:1000] s_r.fsm == ST_AACK);
   COV_WRITE: cover property (s_r.fsm == ST_DACK && s_r.ovr);
   COV_READ: cover property (s_r.fsm == ST_RACK ##[1:300] s_r.fsm == ST_RDAT);
endmodule
`default_nettype wire

// ==== testbench/sap_host_model.sv ====
/*
 Behavioural two-wire host: START, STOP and byte transfers, bit-banged.
 Assumes pull-ups on both lines; the bench works out the wired levels.
*/
`timescale 1ns/1ps
`default_nettype none
module sap_host_model #(
   parameter int H = 8
) (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl_pull,
   output logic sda_pull
);
   // Both lines released at time zero
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end

   // ---------------------------------------------------------------
   // Bit timing
   // ---------------------------------------------------------------
   // Half bit; the target filters pins for four clocks, so eight is the floor
   task automatic half();
      repeat (H) @(posedge clk);
   endtask

   // Byte MSB first plus ninth bit; SDA moves two clocks after SCL falls
   task automatic xfer(input logic [7:0] d, input logic ninth, output logic [7:0] q, output logic ack);
      logic [8:0] bits;
      logic [8:0] seen;
      bits = {d, ninth};
      for (int i = 8; i >= 0; i--) begin
         repeat (2) @(posedge clk);
         sda_pull <= !bits[i];
         half();
         scl_pull <= 1'b0;
         half();
         seen[i] = sda_line;
         scl_pull <= 1'b1;
      end
      q = seen[8:1];
      ack = !seen[0];
   endtask

   // ---------------------------------------------------------------
   // Framing
   // ---------------------------------------------------------------
   // START, then address above the direction bit
   task automatic address(input logic [6:0] a, input logic rd, output logic ack);
      logic [7:0] q;
      half();
      sda_pull <= 1'b1;
      half();
      scl_pull <= 1'b1;
      xfer({a, rd}, 1'b1, q, ack);
   endtask

   // STOP: SDA rises while SCL is high, then bus idle
   task automatic stop();
      repeat (2) @(posedge clk);
      sda_pull <= 1'b1;
      half();
      scl_pull <= 1'b0;
      half();
      sda_pull <= 1'b0;
      half();
   endtask
endmodule
`default_nettype wire

// ==== testbench/test_smbus_address_phase_select.sv ====
/*
 Self-checking bench for the address and phase select block: strap
 decode over resets, bus writes and reads, alert, event line, sync role.
 Assumes the design files and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_smbus_address_phase_select;
   // ---------------------------------------------------------------
   // Signals and wiring
   // ---------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   sap_pkg::sap_strap_t up = '0;
   sap_pkg::sap_strap_t lo = '0;
   logic [1:0] sync_sel = 2'h0;
   logic fault_event = 1'b0;
   logic event_drive = 1'b0;
   logic evt_pull = 1'b0;
   logic sync_i = 1'b0;
   logic scl_pull;
   logic sda_pull;
   sap_pkg::sap_od_t sda_od;
   sap_pkg::sap_od_t alert;
   sap_pkg::sap_od_t evt;
   logic event_seen;
   logic sync_as_output;
   logic [6:0] bus_addr;
   logic addr_ok;
   logic [4:0] phase_step;
   logic phase_override;
   int err_total = 0;
   int n_tests = 0;
   // Wired lines with pull-ups
   wire logic scl_line = !scl_pull;
   wire logic sda_line = !(sda_pull | sda_od.oe);
   wire logic evt_line = !(evt_pull | evt.oe);

   always #10 clk = ~clk;

   sap_top i_dut (
      .clk(clk), .rst(rst), .ce(ce), .address_strap_upper(up), .address_strap_lower(lo),
      .sync_sel(sync_sel), .scl_i(scl_line), .sda_i(sda_line), .sda_od(sda_od),
      .fault_event(fault_event), .fault_alert_output(alert), .event_drive(event_drive),
      .interdevice_event_line_i(evt_line), .interdevice_event_line(evt), .event_seen(event_seen),
      .sync_i(sync_i), .sync_as_output(sync_as_output), .bus_addr(bus_addr), .addr_ok(addr_ok),
      .phase_step(phase_step), .phase_override(phase_override)
   );

   sap_host_model #(.H(8)) i_host (.clk(clk), .sda_line(sda_line), .scl_pull(scl_pull), .sda_pull(sda_pull));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   function automatic sap_pkg::sap_strap_t tri3(input int v);
      return '{res_mode: 1'b0, level: sap_pkg::sap_level_t'(v), index: 5'h00};
   endfunction

   function automatic sap_pkg::sap_strap_t res(input int i);
      return '{res_mode: 1'b1, level: sap_pkg::SAP_LVL_LOW, index: 5'(i)};
   endfunction

   // Straps only count at reset release, so every setting needs a reset
   task automatic boot(input sap_pkg::sap_strap_t u, input sap_pkg::sap_strap_t l, input logic [1:0] s);
      @(posedge clk);
      rst <= 1'b1;
      up <= u;
      lo <= l;
      sync_sel <= s;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (12) @(posedge clk);
   endtask

   // Expected address a; negative means no valid address
   task automatic decode(input sap_pkg::sap_strap_t u, input sap_pkg::sap_strap_t l, input int a);
      boot(u, l, sap_pkg::SYNC_IN);
      check(8'(addr_ok), 8'(a >= 0 && a != 75), "valid");
      if (a >= 0 && a != 75) begin
         check({1'b0, bus_addr}, 8'(a), "address");
         check({3'h0, phase_step}, 8'((a % 8) * 2), "default phase");
         lo <= ~l;
         repeat (10) @(posedge clk);
         check({1'b0, bus_addr}, 8'(a), "held");
      end
   endtask

   // Write one byte; phase checked only when the target answers
   task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic hit, input logic [4:0] ph, input logic ov);
      logic ack;
      logic [7:0] q;
      i_host.address(a, 1'b0, ack);
      check(8'(ack), 8'(hit), "address ack");
      if (hit) begin
         i_host.xfer(d, 1'b1, q, ack);
         check(8'(ack), 8'h01, "data ack");
      end
      i_host.stop();
      if (hit) begin
         check({3'h0, phase_step}, {3'h0, ph}, "phase");
         check(8'(phase_override), 8'(ov), "override");
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_straps();
      for (int u = 0; u < 3; u++) begin
         for (int l = 0; l < 3; l++) begin
            decode(tri3(u), tri3(l), (u == 2 && l == 2) ? -1 : 32 + 3 * u + l);
         end
      end
      decode(tri3(0), res(0), 0);
      decode(tri3(0), res(24), 24);
      decode(tri3(0), res(25), -1);
      decode(res(4), res(24), 124);
      decode(res(5), res(4), 1);
      decode(res(24), res(24), 112);
      decode(res(1), res(25), -1);
      decode(res(0), tri3(0), -1);
   endtask

   task automatic t_sync();
      boot(tri3(0), tri3(0), sap_pkg::SYNC_OUT);
      check(8'(sync_as_output), 8'h01, "sync out");
      boot(tri3(0), tri3(0), sap_pkg::SYNC_IN);
      check(8'(sync_as_output), 8'h00, "sync in");
      boot(tri3(0), tri3(0), sap_pkg::SYNC_AUTO);
      check(8'(sync_as_output), 8'h01, "sync auto idle");
      sync_i <= 1'b1;
      repeat (10) @(posedge clk);
      check(8'(sync_as_output), 8'h00, "sync auto found");
      sync_i <= 1'b0;
   endtask

   // Target at 0x21: set, refuse, ignore out of range, top step, restore
   task automatic t_write();
      boot(tri3(0), tri3(1), sap_pkg::SYNC_IN);
      wr(7'h21, 8'h0a, 1'b1, 5'h0a, 1'b1);
      wr(7'h22, 8'h03, 1'b0, 5'h0a, 1'b1);
      wr(7'h21, 8'h11, 1'b1, 5'h0a, 1'b1);
      wr(7'h21, 8'h10, 1'b1, 5'h10, 1'b1);
      wr(7'h21, 8'h80, 1'b1, 5'h02, 1'b0);
   endtask

   // Alert rises one clock after the fault, clears after a status read
   task automatic t_alert();
      logic ack;
      logic [7:0] q;
      check({6'h00, alert}, 8'h00, "alert idle");
      @(posedge clk);
      fault_event <= 1'b1;
      @(posedge clk);
      fault_event <= 1'b0;
      #1;
      check({6'h00, alert}, 8'h01, "alert set");
      i_host.address(7'h21, 1'b1, ack);
      check(8'(ack), 8'h01, "read ack");
      i_host.xfer(8'hff, 1'b0, q, ack);
      check(q, 8'h82, "status byte");
      i_host.xfer(8'hff, 1'b1, q, ack);
      check(q, 8'h02, "repeat byte");
      i_host.stop();
      check({6'h00, alert}, 8'h00, "alert cleared");
      // Clock enable low: a fault must not reach the alert flop
      ce <= 1'b0;
      fault_event <= 1'b1;
      @(posedge clk);
      fault_event <= 1'b0;
      repeat (2) @(posedge clk);
      check({6'h00, alert}, 8'h00, "alert frozen");
      ce <= 1'b1;
   endtask

   // Own pull and another member's pull both show on the wired line
   task automatic t_event();
      @(posedge clk);
      event_drive <= 1'b1;
      @(posedge clk);
      #1;
      check({6'h00, evt}, 8'h01, "event pull");
      repeat (6) @(posedge clk);
      check(8'(event_seen), 8'h01, "event own");
      event_drive <= 1'b0;
      evt_pull <= 1'b1;
      repeat (6) @(posedge clk);
      check({6'h00, evt}, 8'h00, "event release");
      check(8'(event_seen), 8'h01, "event other");
      evt_pull <= 1'b0;
      repeat (6) @(posedge clk);
      check(8'(event_seen), 8'h00, "event idle");
   endtask

   // Device strapped to the test address answers nothing
   task automatic t_reserved();
      decode(res(3), res(0), 75);
      wr(7'h4b, 8'h05, 1'b0, 5'h00, 1'b0);
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      t_straps();
      t_sync();
      t_write();
      t_alert();
      t_event();
      t_reserved();
      stop_test();
   end

   // The run needs roughly 3300 clocks; allow plenty more
   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      stop_test();
   end
endmodule
`default_nettype wire
